// File: common/acrc_defines.vh
/*
 Register indices, field positions and reset values of the clock and
 rate configuration block. Definitions only; included by the block's files.
*/
`ifndef ACRC_DEFINES_VH
`define ACRC_DEFINES_VH

// Register indices; byte address is four times the index
`define ACRC_IDX_CORE_RATE_SELECT_2      10'h103
`define ACRC_IDX_CORE_RATE_SELECT_3      10'h104
`define ACRC_IDX_CORE_RATE_REPORT_1      10'h10A
`define ACRC_IDX_CORE_RATE_REPORT_2      10'h10B
`define ACRC_IDX_CORE_RATE_REPORT_3      10'h10C
`define ACRC_IDX_SECOND_CLOCK_SETUP      10'h112
`define ACRC_IDX_SECOND_RATE_SELECT_1    10'h113
`define ACRC_IDX_SECOND_RATE_SELECT_2    10'h114
`define ACRC_IDX_SECOND_RATE_REPORT_1    10'h11B
`define ACRC_IDX_SECOND_RATE_REPORT_2    10'h11C
`define ACRC_IDX_CORE_OUTPUT_SETUP       10'h149
`define ACRC_IDX_SECOND_OUTPUT_SETUP     10'h14A

// Field positions
`define ACRC_RATE_MSB                    4
`define ACRC_FREQ_MSB                    10
`define ACRC_FREQ_LSB                    8
`define ACRC_ENABLE_BIT                  6
`define ACRC_SRC_MSB                     3
`define ACRC_OUT_ENABLE_BIT              15
`define ACRC_DIV_MSB                     7
`define ACRC_DIV_LSB                     3
`define ACRC_SEL_MSB                     2

// Reset values
`define ACRC_RATE_SELECT_RESET           5'h11
`define ACRC_RATE_REPORT_RESET           5'h00
`define ACRC_FREQ_RESET                  3'h3
`define ACRC_SRC_RESET                   4'h5
`define ACRC_OUT_SETUP_RESET             16'h0000

// Codes
`define ACRC_FREQ_MAX_CODE               3'h3
`define ACRC_FAMILY_44K                  2'h1
`define ACRC_BASE_48K_100HZ              24'h00F000
`define ACRC_BASE_44K_100HZ              24'h00DC80

`endif

// File: hdl/acrc_clock_divider.v
/*
 Divides a stream of source-rate enable pulses by a 5-bit code and emits
 one pulse per period. Assumes the source pulses are on the same clock.
*/
`timescale 1ns/1ps
module acrc_clock_divider
(
	clk,
	reset,
	enable,
	source_tick,
	divide_code,
	out_tick_q
);
	input  wire       clk;
	input  wire       reset;
	input  wire       enable;
	input  wire       source_tick;
	input  wire [4:0] divide_code;
	output reg        out_tick_q;

	reg  [4:0] count_q;
	wire [4:0] last_count;

	// Codes 0 and 1 both mean divide by one
	assign last_count = (divide_code < 5'h02) ? 5'h00 : (divide_code - 5'h01);

	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			count_q    <= 5'h00;
			out_tick_q <= 1'b0;
		end
		else if (!enable)
		begin
			count_q    <= 5'h00;
			out_tick_q <= 1'b0;
		end
		else
		begin
			out_tick_q <= 1'b0;
			if (source_tick)
			begin
				if (count_q >= last_count)
				begin
					count_q    <= 5'h00;
					out_tick_q <= 1'b1;
				end
				else
					count_q <= count_q + 5'h01;
			end
		end
	end
endmodule // acrc_clock_divider

// File: hdl/acrc_clock_rate_config.v
/*
 Wishbone register file for core and second domain rate selects, rate
 reports, second domain clock setup and the two derived clock outputs,
 plus the clock sufficiency check for path enables. Assumes rate reports,
 source ticks and path requests come from logic on clk.
*/
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "acrc_defines.vh"

module acrc_clock_rate_config
(
	clk,
	reset,
	wb_cyc_i,
	wb_stb_i,
	wb_we_i,
	wb_adr_i,
	wb_sel_i,
	wb_dat_i,
	wb_dat_o,
	wb_ack_o,
	core_rate_report_1,
	core_rate_report_2,
	core_rate_report_3,
	second_domain_rate_report_1,
	second_domain_rate_report_2,
	core_domain_clock_enable,
	core_domain_clock_freq_code,
	core_source_tick,
	second_source_tick,
	path_request,
	path_domain,
	path_need_code,
	second_clock_enable_q,
	second_clock_source_onehot_q,
	second_clock_rate_100hz_q,
	core_clock_output_rate_100hz_q,
	core_clock_output_q,
	second_clock_output_q,
	path_granted_q,
	path_refused_q,
	core_paths_active_q,
	second_paths_active_q
);
	input  wire        clk;
	input  wire        reset;
	input  wire        wb_cyc_i;
	input  wire        wb_stb_i;
	input  wire        wb_we_i;
	input  wire [11:0] wb_adr_i;
	input  wire [3:0]  wb_sel_i;
	input  wire [31:0] wb_dat_i;
	output reg  [31:0] wb_dat_o;
	output reg         wb_ack_o;
	input  wire [4:0]  core_rate_report_1;
	input  wire [4:0]  core_rate_report_2;
	input  wire [4:0]  core_rate_report_3;
	input  wire [4:0]  second_domain_rate_report_1;
	input  wire [4:0]  second_domain_rate_report_2;
	input  wire        core_domain_clock_enable;
	input  wire [2:0]  core_domain_clock_freq_code;
	input  wire        core_source_tick;
	input  wire        second_source_tick;
	input  wire        path_request;
	input  wire        path_domain;
	input  wire [2:0]  path_need_code;
	output reg         second_clock_enable_q;
	output reg  [6:0]  second_clock_source_onehot_q;
	output reg  [23:0] second_clock_rate_100hz_q;
	output reg  [23:0] core_clock_output_rate_100hz_q;
	output wire        core_clock_output_q;
	output wire        second_clock_output_q;
	output reg         path_granted_q;
	output reg         path_refused_q;
	output reg         core_paths_active_q;
	output reg         second_paths_active_q;

	reg  [4:0]  core_rate_select_2_q;
	reg  [4:0]  core_rate_select_3_q;
	reg  [4:0]  core_rate_report_1_q;
	reg  [4:0]  core_rate_report_2_q;
	reg  [4:0]  core_rate_report_3_q;
	reg  [2:0]  second_clock_freq_code_q;
	reg  [3:0]  second_clock_source_sel_q;
	reg  [4:0]  second_rate_select_1_q;
	reg  [4:0]  second_rate_select_2_q;
	reg  [4:0]  second_rate_report_1_q;
	reg  [4:0]  second_rate_report_2_q;
	reg         core_clock_output_enable_q;
	reg  [4:0]  core_clock_output_divider_q;
	reg  [2:0]  core_clock_output_freq_code_q;
	reg         second_clock_output_enable_q;
	reg  [4:0]  second_clock_output_divider_q;
	reg  [2:0]  second_clock_output_freq_code_q;
	reg  [15:0] read_d;
	reg  [6:0]  onehot_d;

	wire        access;
	wire        write_strobe;
	wire [9:0]  reg_index;
	wire [15:0] write_data;
	wire        second_family_44k;
	wire        core_family_44k;
	wire        second_clock_running;
	wire [2:0]  domain_code;
	wire        domain_running;
	wire [15:0] core_out_image;
	wire [15:0] second_out_image;

	// Merges byte lanes 0 and 1 of a write into a 16-bit register image
	function [15:0] merge_lanes;
		input [15:0] old_value;
		input [15:0] new_value;
		input [1:0]  lanes;
		begin
			merge_lanes[7:0]  = lanes[0] ? new_value[7:0] : old_value[7:0];
			merge_lanes[15:8] = lanes[1] ? new_value[15:8] : old_value[15:8];
		end
	endfunction

	// A rate code of the form 01XXX belongs to the 44.1 kHz family
	function is_family_44k;
		input [4:0] rate_code;
		begin
			is_family_44k = (rate_code[4:3] == `ACRC_FAMILY_44K);
		end
	endfunction

	// Clock rate in units of 100 Hz; reserved codes give zero
	function [23:0] clock_rate_100hz;
		input [2:0] freq_code;
		input       family_44k;
		reg   [23:0] base;
		begin
			base = family_44k ? `ACRC_BASE_44K_100HZ : `ACRC_BASE_48K_100HZ;
			if (freq_code > `ACRC_FREQ_MAX_CODE)
				clock_rate_100hz = 24'h000000;
			else
				clock_rate_100hz = base << freq_code[1:0];
		end
	endfunction

	// Classic Wishbone: one registered ack per request, dropped the next cycle
	assign access       = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign write_strobe = access && wb_we_i;
	assign reg_index    = wb_adr_i[11:2];
	assign write_data   = wb_dat_i[15:0];

	// Register images after a lane-merged write; fields are picked out by position
	assign core_out_image   = merge_lanes({core_clock_output_enable_q, 7'h00, core_clock_output_divider_q,
		core_clock_output_freq_code_q}, write_data, wb_sel_i[1:0]);
	assign second_out_image = merge_lanes({second_clock_output_enable_q, 7'h00, second_clock_output_divider_q,
		second_clock_output_freq_code_q}, write_data, wb_sel_i[1:0]);

	// Either second domain select may carry the 44.1 kHz family
	assign second_family_44k = is_family_44k(second_rate_select_1_q) || is_family_44k(second_rate_select_2_q);
	assign core_family_44k   = is_family_44k(core_rate_select_2_q) || is_family_44k(core_rate_select_3_q);

	// A reserved source leaves the second domain without a clock
	assign second_clock_running = second_clock_enable_q && (onehot_d != 7'h00) &&
		(second_clock_freq_code_q <= `ACRC_FREQ_MAX_CODE);
	assign domain_code    = path_domain ? second_clock_freq_code_q : core_domain_clock_freq_code;
	assign domain_running = path_domain ? second_clock_running : core_domain_clock_enable;

	always @*
	begin
		case (second_clock_source_sel_q)
			4'h0: onehot_d = 7'h01;
			4'h1: onehot_d = 7'h02;
			4'h4: onehot_d = 7'h04;
			4'h5: onehot_d = 7'h08;
			4'h8: onehot_d = 7'h10;
			4'h9: onehot_d = 7'h20;
			4'hA: onehot_d = 7'h40;
			default: onehot_d = 7'h00;
		endcase
	end

	always @*
	begin
		read_d = 16'h0000;
		case (reg_index)
			`ACRC_IDX_CORE_RATE_SELECT_2:   read_d = {11'h000, core_rate_select_2_q};
			`ACRC_IDX_CORE_RATE_SELECT_3:   read_d = {11'h000, core_rate_select_3_q};
			`ACRC_IDX_CORE_RATE_REPORT_1:   read_d = {11'h000, core_rate_report_1_q};
			`ACRC_IDX_CORE_RATE_REPORT_2:   read_d = {11'h000, core_rate_report_2_q};
			`ACRC_IDX_CORE_RATE_REPORT_3:   read_d = {11'h000, core_rate_report_3_q};
			`ACRC_IDX_SECOND_CLOCK_SETUP:   read_d = {5'h00, second_clock_freq_code_q, 1'b0,
				second_clock_enable_q, 2'h0, second_clock_source_sel_q};
			`ACRC_IDX_SECOND_RATE_SELECT_1: read_d = {11'h000, second_rate_select_1_q};
			`ACRC_IDX_SECOND_RATE_SELECT_2: read_d = {11'h000, second_rate_select_2_q};
			`ACRC_IDX_SECOND_RATE_REPORT_1: read_d = {11'h000, second_rate_report_1_q};
			`ACRC_IDX_SECOND_RATE_REPORT_2: read_d = {11'h000, second_rate_report_2_q};
			`ACRC_IDX_CORE_OUTPUT_SETUP:    read_d = {core_clock_output_enable_q, 7'h00,
				core_clock_output_divider_q, core_clock_output_freq_code_q};
			`ACRC_IDX_SECOND_OUTPUT_SETUP:  read_d = {second_clock_output_enable_q, 7'h00,
				second_clock_output_divider_q, second_clock_output_freq_code_q};
			default: read_d = 16'h0000;
		endcase
	end

	// Bus answer; unmapped addresses are acknowledged and read as zero
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= access;
			if (access && !wb_we_i)
				wb_dat_o <= {16'h0000, read_d};
		end
	end

	// Status fields follow the rate logic; bus writes cannot touch them
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			core_rate_report_1_q   <= `ACRC_RATE_REPORT_RESET;
			core_rate_report_2_q   <= `ACRC_RATE_REPORT_RESET;
			core_rate_report_3_q   <= `ACRC_RATE_REPORT_RESET;
			second_rate_report_1_q <= `ACRC_RATE_REPORT_RESET;
			second_rate_report_2_q <= `ACRC_RATE_REPORT_RESET;
		end
		else
		begin
			core_rate_report_1_q   <= core_rate_report_1;
			core_rate_report_2_q   <= core_rate_report_2;
			core_rate_report_3_q   <= core_rate_report_3;
			second_rate_report_1_q <= second_domain_rate_report_1;
			second_rate_report_2_q <= second_domain_rate_report_2;
		end
	end

	// Writable registers; reserved codes are stored as written
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			core_rate_select_2_q            <= `ACRC_RATE_SELECT_RESET;
			core_rate_select_3_q            <= `ACRC_RATE_SELECT_RESET;
			second_clock_freq_code_q        <= `ACRC_FREQ_RESET;
			second_clock_enable_q           <= 1'b0;
			second_clock_source_sel_q       <= `ACRC_SRC_RESET;
			second_rate_select_1_q          <= `ACRC_RATE_SELECT_RESET;
			second_rate_select_2_q          <= `ACRC_RATE_SELECT_RESET;
			core_clock_output_enable_q      <= 1'b0;
			core_clock_output_divider_q     <= 5'h00;
			core_clock_output_freq_code_q   <= 3'h0;
			second_clock_output_enable_q    <= 1'b0;
			second_clock_output_divider_q   <= 5'h00;
			second_clock_output_freq_code_q <= 3'h0;
		end
		else if (write_strobe)
		begin
			case (reg_index)
				`ACRC_IDX_CORE_RATE_SELECT_2:
					if (wb_sel_i[0]) core_rate_select_2_q <= write_data[`ACRC_RATE_MSB:0];
				`ACRC_IDX_CORE_RATE_SELECT_3:
					if (wb_sel_i[0]) core_rate_select_3_q <= write_data[`ACRC_RATE_MSB:0];
				`ACRC_IDX_SECOND_CLOCK_SETUP:
				begin
					if (wb_sel_i[1])
						second_clock_freq_code_q <= write_data[`ACRC_FREQ_MSB:`ACRC_FREQ_LSB];
					if (wb_sel_i[0])
					begin
						// Software sequences source and enable; no hardware interlock
						second_clock_enable_q     <= write_data[`ACRC_ENABLE_BIT];
						second_clock_source_sel_q <= write_data[`ACRC_SRC_MSB:0];
					end
				end
				`ACRC_IDX_SECOND_RATE_SELECT_1:
					if (wb_sel_i[0]) second_rate_select_1_q <= write_data[`ACRC_RATE_MSB:0];
				`ACRC_IDX_SECOND_RATE_SELECT_2:
					if (wb_sel_i[0]) second_rate_select_2_q <= write_data[`ACRC_RATE_MSB:0];
				`ACRC_IDX_CORE_OUTPUT_SETUP:
				begin
					core_clock_output_enable_q    <= core_out_image[`ACRC_OUT_ENABLE_BIT];
					core_clock_output_divider_q   <= core_out_image[`ACRC_DIV_MSB:`ACRC_DIV_LSB];
					core_clock_output_freq_code_q <= core_out_image[`ACRC_SEL_MSB:0];
				end
				`ACRC_IDX_SECOND_OUTPUT_SETUP:
				begin
					second_clock_output_enable_q    <= second_out_image[`ACRC_OUT_ENABLE_BIT];
					second_clock_output_divider_q   <= second_out_image[`ACRC_DIV_MSB:`ACRC_DIV_LSB];
					second_clock_output_freq_code_q <= second_out_image[`ACRC_SEL_MSB:0];
				end
				default:
					second_clock_enable_q <= second_clock_enable_q;
			endcase
		end
	end

	// Decoded clock state seen by the rest of the chip
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			second_clock_source_onehot_q   <= 7'h00;
			second_clock_rate_100hz_q      <= 24'h000000;
			core_clock_output_rate_100hz_q <= 24'h000000;
		end
		else
		begin
			second_clock_source_onehot_q   <= second_clock_enable_q ? onehot_d : 7'h00;
			second_clock_rate_100hz_q      <= clock_rate_100hz(second_clock_freq_code_q, second_family_44k);
			// Output frequency is trusted to stay within the core clock
			core_clock_output_rate_100hz_q <= clock_rate_100hz(core_clock_output_freq_code_q, core_family_44k);
		end
	end

	// Path enable check; a refusal leaves running paths as they are
	always @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			path_granted_q        <= 1'b0;
			path_refused_q        <= 1'b0;
			core_paths_active_q   <= 1'b0;
			second_paths_active_q <= 1'b0;
		end
		else
		begin
			path_granted_q <= 1'b0;
			path_refused_q <= 1'b0;
			if (path_request)
			begin
				if (domain_running && (domain_code >= path_need_code))
				begin
					path_granted_q <= 1'b1;
					if (path_domain)
						second_paths_active_q <= 1'b1;
					else
						core_paths_active_q <= 1'b1;
				end
				else
					path_refused_q <= 1'b1;
			end
		end
	end

	acrc_clock_divider core_output_divider
	(
		.clk         (clk),
		.reset       (reset),
		.enable      (core_clock_output_enable_q),
		.source_tick (core_source_tick),
		.divide_code (core_clock_output_divider_q),
		.out_tick_q  (core_clock_output_q)
	);

	acrc_clock_divider second_output_divider
	(
		.clk         (clk),
		.reset       (reset),
		.enable      (second_clock_output_enable_q && second_clock_running),
		.source_tick (second_source_tick),
		.divide_code (second_clock_output_divider_q),
		.out_tick_q  (second_clock_output_q)
	);
endmodule // acrc_clock_rate_config

// File: tb/acrc_checker.sv
/*
 Port assertions for the clock and rate configuration block.
 Assumes one clock and an asynchronous active-high reset; bound below.
*/
`timescale 1ns/1ps
module acrc_checker
(
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        core_domain_clock_enable,
	input wire logic [2:0]  core_domain_clock_freq_code,
	input wire logic        core_source_tick,
	input wire logic        second_source_tick,
	input wire logic        path_request,
	input wire logic        path_domain,
	input wire logic [2:0]  path_need_code,
	input wire logic        second_clock_enable_q,
	input wire logic [6:0]  second_clock_source_onehot_q,
	input wire logic        core_clock_output_q,
	input wire logic        second_clock_output_q,
	input wire logic        path_granted_q,
	input wire logic        path_refused_q,
	input wire logic        core_paths_active_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_ack_rise; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000; endproperty
	a_ack_rise: assert property (p_ack_rise) else $error("bus answer missing");
	property p_path_quiet; !path_request |=> !path_granted_q && !path_refused_q; endproperty
	a_path_quiet: assert property (p_path_quiet) else $error("path answer without request");
	property p_core_off; path_request && !path_domain && !core_domain_clock_enable |=> path_refused_q; endproperty
	a_core_off: assert property (p_core_off) else $error("core path granted without clock");
	property p_core_slow; path_request && !path_domain && path_need_code > core_domain_clock_freq_code
		|=> path_refused_q && !path_granted_q; endproperty
	a_core_slow: assert property (p_core_slow) else $error("core path granted on slow clock");
	property p_core_ok; path_request && !path_domain && core_domain_clock_enable
		&& path_need_code <= core_domain_clock_freq_code |=> path_granted_q && core_paths_active_q; endproperty
	a_core_ok: assert property (p_core_ok) else $error("core path not granted");
	property p_second_off; path_request && path_domain && !second_clock_enable_q |=> path_refused_q; endproperty
	a_second_off: assert property (p_second_off) else $error("second path granted while off");
	property p_sticky; core_paths_active_q |=> core_paths_active_q; endproperty
	a_sticky: assert property (p_sticky) else $error("active path dropped");
	property p_onehot; $onehot0(second_clock_source_onehot_q); endproperty
	a_onehot: assert property (p_onehot) else $error("two sources selected");
	property p_out_tick; core_clock_output_q || second_clock_output_q
		|-> $past(core_source_tick) || $past(second_source_tick); endproperty
	a_out_tick: assert property (p_out_tick) else $error("output pulse without source tick");
endmodule // acrc_checker

bind acrc_clock_rate_config acrc_checker i_acrc_checker (.*);

// File: tb/test_async_clock_and_rate_config.sv
/*
 Self-checking bench for the clock and rate configuration block.
 Assumes a 125 MHz clock; bus accesses hold the request until ack, with no fixed latency.
*/
`timescale 1ns/1ps
module test_async_clock_and_rate_config;
	logic        clk, reset, cyc, stb, we, ack, cen, ctick, stick, preq, pdom;
	logic        s_en, c_out, s_out, granted, refused, c_act, s_act;
	logic [3:0]  sel;
	logic [11:0] adr;
	logic [31:0] wdat, rdat;
	logic [4:0]  rep [5];
	logic [2:0]  cfreq, pneed;
	logic [6:0]  s_oh;
	logic [23:0] s_rate, c_rate;
	logic [15:0] rd;
	int          errors, n_checks;

	acrc_clock_rate_config i_acrc_clock_rate_config
	(
		.clk                            (clk),
		.reset                          (reset),
		.wb_cyc_i                       (cyc),
		.wb_stb_i                       (stb),
		.wb_we_i                        (we),
		.wb_adr_i                       (adr),
		.wb_sel_i                       (sel),
		.wb_dat_i                       (wdat),
		.wb_dat_o                       (rdat),
		.wb_ack_o                       (ack),
		.core_rate_report_1             (rep[0]),
		.core_rate_report_2             (rep[1]),
		.core_rate_report_3             (rep[2]),
		.second_domain_rate_report_1    (rep[3]),
		.second_domain_rate_report_2    (rep[4]),
		.core_domain_clock_enable       (cen),
		.core_domain_clock_freq_code    (cfreq),
		.core_source_tick               (ctick),
		.second_source_tick             (stick),
		.path_request                   (preq),
		.path_domain                    (pdom),
		.path_need_code                 (pneed),
		.second_clock_enable_q          (s_en),
		.second_clock_source_onehot_q   (s_oh),
		.second_clock_rate_100hz_q      (s_rate),
		.core_clock_output_rate_100hz_q (c_rate),
		.core_clock_output_q            (c_out),
		.second_clock_output_q          (s_out),
		.path_granted_q                 (granted),
		.path_refused_q                 (refused),
		.core_paths_active_q            (c_act),
		.second_paths_active_q          (s_act)
	);

	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Holds the request until ack is sampled high; no fixed latency assumed
	task automatic bus(input logic [9:0] idx, input logic w, input logic [15:0] d);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		sel <= 4'h3;
		adr <= {idx, 2'h0};
		wdat <= {16'hFFFF, d};
		// Only the watchdog ends a wait for the answer
		do
			@(posedge clk);
		while (ack !== 1'h1);
		chk("ack", ack, 1'h1);
		rd = rdat[15:0];
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask

	task automatic t_reset;
		logic [9:0]  idx [12] = '{10'h103, 10'h104, 10'h10A, 10'h10B, 10'h10C, 10'h112, 10'h113, 10'h114,
			10'h11B, 10'h11C, 10'h149, 10'h14A};
		logic [15:0] exp [12] = '{16'h0011, 16'h0011, 16'h0000, 16'h0000, 16'h0000, 16'h0305, 16'h0011,
			16'h0011, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		for (int i = 0; i < 12; i++)
		begin
			bus(idx[i], 1'h0, 16'h0000);
			chk("reset value", rd, exp[i]);
		end
		bus(10'h105, 1'h1, 16'hFFFF);
		bus(10'h105, 1'h0, 16'h0000);
		chk("unmapped read", rd, 16'h0000);
	endtask

	// Writes to status places must not disturb what the rate logic reports
	task automatic t_ro;
		logic [9:0] idx [5] = '{10'h10A, 10'h10B, 10'h10C, 10'h11B, 10'h11C};
		for (int i = 0; i < 5; i++)
			rep[i] <= 5'h0A + 5'(i);
		for (int i = 0; i < 5; i++)
		begin
			bus(idx[i], 1'h1, 16'h001F);
			bus(idx[i], 1'h0, 16'h0000);
			chk("rate report", rd, {11'h000, 5'h0A + 5'(i)});
		end
	endtask

	task automatic t_rates;
		logic [9:0]  idx [4] = '{10'h103, 10'h104, 10'h113, 10'h114};
		logic [15:0] val [2] = '{16'h000B, 16'h0013};
		for (int v = 0; v < 2; v++)
			for (int i = 0; i < 4; i++)
			begin
				bus(idx[i], 1'h1, val[v]);
				bus(idx[i], 1'h0, 16'h0000);
				chk("rate select", rd, val[v]);
			end
	endtask

	task automatic t_second;
		logic [3:0] src [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'h2};
		logic [6:0] oh [8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00};
		for (int i = 0; i < 8; i++)
		begin
			bus(10'h112, 1'h1, {8'h02, 4'h0, src[i]});
			bus(10'h112, 1'h1, {8'h02, 4'h4, src[i]});
			@(posedge clk);
			#1;
			chk("source select", s_oh, oh[i]);
		end
		for (int f = 0; f < 2; f++)
		begin
			bus(10'h113, 1'h1, f ? 16'h000B : 16'h0011);
			for (int j = 0; j < 5; j++)
			begin
				bus(10'h112, 1'h1, {5'h00, 3'(j), 8'h45});
				@(posedge clk);
				#1;
				chk("second rate", s_rate, j > 3 ? 24'h000000 : (f ? 24'h00DC80 : 24'h00F000) << j);
			end
		end
		bus(10'h112, 1'h1, 16'h0345);
		bus(10'h112, 1'h0, 16'h0000);
		chk("clock setup", rd, 16'h0345);
	endtask

	task automatic path(input logic dom, input logic [2:0] need, input logic exp);
		@(posedge clk);
		preq <= 1'h1;
		pdom <= dom;
		pneed <= need;
		@(posedge clk);
		preq <= 1'h0;
		#1;
		chk("granted", granted, exp);
		chk("refused", refused, !exp);
	endtask

	task automatic t_paths;
		path(1'h0, 3'h0, 1'h0);
		@(posedge clk);
		cen <= 1'h1;
		cfreq <= 3'h3;
		path(1'h0, 3'h4, 1'h0);
		chk("core active", c_act, 1'h0);
		path(1'h0, 3'h3, 1'h1);
		path(1'h1, 3'h3, 1'h1);
		bus(10'h112, 1'h1, 16'h0305);
		chk("second enable", s_en, 1'h0);
		path(1'h1, 3'h0, 1'h0);
		chk("second active", s_act, 1'h1);
		// A reserved source or a reserved frequency leaves the domain without a clock
		bus(10'h112, 1'h1, 16'h0342);
		path(1'h1, 3'h0, 1'h0);
		bus(10'h112, 1'h1, 16'h0305);
		bus(10'h112, 1'h1, 16'h0445);
		path(1'h1, 3'h0, 1'h0);
		bus(10'h112, 1'h1, 16'h0305);
		bus(10'h112, 1'h1, 16'h0345);
		chk("second enable", s_en, 1'h1);
	endtask

	// Every divide ratio used is a factor of 12 so no residue carries over
	task automatic t_outs;
		logic [15:0] set [5] = '{16'h8000, 16'h8008, 16'h8018, 16'h8020, 16'h0018};
		int          exp [5] = '{12, 12, 4, 3, 0};
		int          nc, ns;
		for (int i = 0; i < 5; i++)
		begin
			bus(10'h149, 1'h1, set[i]);
			bus(10'h14A, 1'h1, set[i]);
			bus(10'h14A, 1'h0, 16'h0000);
			chk("output setup", rd, set[i]);
			chk("core output rate", c_rate, 24'h00F000);
			nc = 0;
			ns = 0;
			repeat (24)
			begin
				@(posedge clk);
				ctick <= !ctick;
				stick <= !stick;
				#1;
				nc += c_out;
				ns += s_out;
			end
			chk("core pulses", nc, exp[i]);
			chk("second pulses", ns, exp[i]);
		end
		// Core select 2 in the 44.1 kHz family moves the output rate to that family
		bus(10'h103, 1'h1, 16'h000B);
		bus(10'h149, 1'h1, 16'h0002);
		@(posedge clk);
		#1;
		chk("core output rate", c_rate, 24'h00DC80 << 2);
		bus(10'h149, 1'h1, 16'h0004);
		@(posedge clk);
		#1;
		chk("core output rate", c_rate, 24'h000000);
	endtask

	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		#100000;
		errors++;
		wrap_up;
	end

	initial
	begin
		{reset, cyc, stb, we, cen, ctick, stick, preq, pdom} = 9'h100;
		{sel, adr, wdat, cfreq, pneed} = '0;
		for (int i = 0; i < 5; i++)
			rep[i] = 5'h00;
		repeat (3) @(posedge clk);
		reset <= 1'h0;
		t_reset;
		t_ro;
		t_rates;
		t_second;
		t_paths;
		t_outs;
		wrap_up;
	end
endmodule // test_async_clock_and_rate_config
